// *** rtl/serial_eeprom_data_memory.sv ***
// serial eeprom data memory behind a bit-banged control register
`timescale 1ns/1ps
module serial_eeprom_data_memory #(
    parameter int WORD_CYCLES = serial_eeprom_pkg::WORD_PROG_CYCLES,
    parameter int ALL_CYCLES = serial_eeprom_pkg::ALL_PROG_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic timer_clk,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_bank,
    input wire logic indirect_pointer_one_access,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [serial_eeprom_pkg::DATA_W-1:0] bus_wdata,
    output logic [serial_eeprom_pkg::DATA_W-1:0] bus_rdata,
    output logic prog_busy,
    output logic prog_enabled
);
    import serial_eeprom_pkg::*;

    localparam int TCNT_W = $clog2(ALL_CYCLES + 1);

    // ****************************************
    // declarations
    // ****************************************
    logic chip_select_bit, serial_clock_bit, serial_in_bit, serial_out_bit, cs_prev, sk_prev;
    frame_state_t state, next_state;
    logic [HEAD_BITS-1:0] head, next_head;
    logic [3:0] bit_cnt, next_cnt;
    logic [DATA_W-1:0] data_sh, next_data;
    logic [ADDR_W-1:0] cur_addr, next_addr;
    prog_action_t action, next_action;
    logic next_en, next_do, launch_word, launch_all;
    logic [DATA_W-1:0] mem [ARRAY_DEPTH];
    logic start_word_tgl, start_all_tgl, run, done_tgl;
    logic done_s1, done_s2, done_seen;
    logic word_s1, word_s2, word_seen, all_s1, all_s2, all_seen;
    logic [TCNT_W-1:0] tcnt;

    // ****************************************
    // decode
    // ****************************************
    wire ctrl_hit = indirect_pointer_one_access && bus_bank == CTRL_BANK
        && bus_addr == CTRL_ADDR;
    wire ctrl_wr = ctrl_hit && bus_wr;
    wire ctrl_rd = ctrl_hit && bus_rd;
    wire sk_rise = serial_clock_bit && !sk_prev;
    wire cs_fall = !chip_select_bit && cs_prev;
    wire [HEAD_BITS-1:0] head_next = {head[HEAD_BITS-2:0], serial_in_bit};
    wire [1:0] head_op = head_next[HEAD_OP_LSB +: 2];
    wire [1:0] head_sub = head_next[HEAD_SUB_LSB +: 2];
    wire [ADDR_W-1:0] head_addr = head_next[ADDR_W-1:0];
    wire [1:0] arm_op = head[HEAD_OP_LSB +: 2];
    wire [1:0] arm_sub = head[HEAD_SUB_LSB +: 2];
    wire head_last = bit_cnt == 4'(HEAD_BITS - 1);
    wire data_last = bit_cnt == 4'(DATA_W - 1);
    wire needs_data = head_op == OP_WRITE
        || (head_op == OP_EXT && head_sub == SUB_WRITE_ALL);
    wire done_evt = done_s2 != done_seen;
    wire apply = state == st_busy && done_evt;
    wire [DATA_W-1:0] cur_byte = mem[cur_addr];
    // msb first: bit 7 - count
    wire read_bit = cur_byte[~bit_cnt[2:0]];
    wire all_op = action == act_erase_all || action == act_write_all;
    wire erase_op = action == act_erase || action == act_erase_all;
    wire [DATA_W-1:0] prog_value = erase_op ? ERASED_BYTE : data_sh;
    wire [DATA_W-1:0] ctrl_value = {serial_out_bit, serial_in_bit, serial_clock_bit,
        chip_select_bit, CTRL_UNUSED};

    // ****************************************
    // frame sequencer
    // ****************************************
    always_comb
    begin
        next_state = state;
        next_head = head;
        next_cnt = bit_cnt;
        next_data = data_sh;
        next_addr = cur_addr;
        next_action = action;
        next_en = prog_enabled;
        launch_word = 1'b0;
        launch_all = 1'b0;
        unique case (state)
            st_idle:
            begin
                if (chip_select_bit && sk_rise && serial_in_bit)
                begin
                    next_state = st_head;
                    next_cnt = 4'h0;
                end
            end
            st_head:
            begin
                if (!chip_select_bit)
                    next_state = st_idle;
                else if (sk_rise)
                begin
                    next_head = head_next;
                    next_cnt = bit_cnt + 4'h1;
                    if (head_last)
                    begin
                        next_cnt = 4'h0;
                        next_addr = head_addr;
                        if (head_op == OP_READ)
                            next_state = st_read;
                        else if (needs_data)
                            next_state = st_data;
                        else
                            next_state = st_armed;
                    end
                end
            end
            st_data:
            begin
                if (!chip_select_bit)
                    next_state = st_idle;
                else if (sk_rise)
                begin
                    next_data = {data_sh[DATA_W-2:0], serial_in_bit};
                    next_cnt = bit_cnt + 4'h1;
                    if (data_last)
                        next_state = st_armed;
                end
            end
            st_read:
            begin
                if (!chip_select_bit)
                    next_state = st_idle;
                else if (sk_rise)
                begin
                    next_cnt = bit_cnt + 4'h1;
                    if (data_last)
                    begin
                        next_cnt = 4'h0;
                        next_addr = cur_addr + ADDR_STEP;
                    end
                end
            end
            st_armed:
            begin
                if (!chip_select_bit)
                begin
                    next_state = st_idle;
                    if (arm_op == OP_EXT)
                    begin
                        if (arm_sub == SUB_ENABLE)
                            next_en = 1'b1;
                        else if (arm_sub == SUB_DISABLE)
                            next_en = 1'b0;
                        else if (prog_enabled)
                        begin
                            next_state = st_busy;
                            launch_all = 1'b1;
                            next_action = arm_sub == SUB_ERASE_ALL ? act_erase_all
                                : act_write_all;
                        end
                    end
                    else if (prog_enabled)
                    begin
                        next_state = st_busy;
                        launch_word = 1'b1;
                        next_action = arm_op == OP_WRITE ? act_write : act_erase;
                    end
                end
            end
            st_busy:
            begin
                if (done_evt)
                    next_state = st_idle;
            end
        endcase
    end

    // data-out level seen in the control register
    assign next_do = !chip_select_bit ? 1'b1
        : (state == st_busy && !done_evt) ? 1'b0
        : (state == st_head && sk_rise && head_last && head_op == OP_READ) ? 1'b0
        : (state == st_read && sk_rise) ? read_bit
        : state == st_read ? serial_out_bit
        : 1'b1;

    // ****************************************
    // control register and sequencer state
    // ****************************************
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            chip_select_bit <= CTRL_RESET[CS_BIT];
            serial_clock_bit <= CTRL_RESET[SK_BIT];
            serial_in_bit <= CTRL_RESET[DI_BIT];
            serial_out_bit <= CTRL_RESET[DO_BIT];
            cs_prev <= CTRL_RESET[CS_BIT];
            sk_prev <= CTRL_RESET[SK_BIT];
            bus_rdata <= '0;
        end
        else
        begin
            chip_select_bit <= ctrl_wr ? bus_wdata[CS_BIT] : chip_select_bit;
            serial_clock_bit <= ctrl_wr ? bus_wdata[SK_BIT] : serial_clock_bit;
            serial_in_bit <= ctrl_wr ? bus_wdata[DI_BIT] : serial_in_bit;
            serial_out_bit <= next_do;
            cs_prev <= chip_select_bit;
            sk_prev <= serial_clock_bit;
            bus_rdata <= ctrl_rd ? ctrl_value : '0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= st_idle;
            head <= '0;
            bit_cnt <= 4'h0;
            data_sh <= '0;
            cur_addr <= '0;
            action <= act_write;
            prog_enabled <= 1'b0;
            prog_busy <= 1'b0;
        end
        else
        begin
            state <= next_state;
            head <= next_head;
            bit_cnt <= next_cnt;
            data_sh <= next_data;
            cur_addr <= next_addr;
            action <= next_action;
            prog_enabled <= next_en;
            prog_busy <= next_state == st_busy;
        end
    end

    // ****************************************
    // crossing to and from the program timer
    // ****************************************
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            start_word_tgl <= 1'b0;
            start_all_tgl <= 1'b0;
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
            done_seen <= 1'b0;
        end
        else
        begin
            start_word_tgl <= start_word_tgl ^ launch_word;
            start_all_tgl <= start_all_tgl ^ launch_all;
            done_s1 <= done_tgl;
            done_s2 <= done_s1;
            done_seen <= done_s2;
        end
    end

    always_ff @(posedge timer_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            word_s1 <= 1'b0;
            word_s2 <= 1'b0;
            all_s1 <= 1'b0;
            all_s2 <= 1'b0;
        end
        else
        begin
            word_s1 <= start_word_tgl;
            word_s2 <= word_s1;
            all_s1 <= start_all_tgl;
            all_s2 <= all_s1;
        end
    end

    // self-timed program cycle, needs no serial clock
    always_ff @(posedge timer_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            word_seen <= 1'b0;
            all_seen <= 1'b0;
            run <= 1'b0;
            done_tgl <= 1'b0;
            tcnt <= '0;
        end
        else if (word_s2 != word_seen || all_s2 != all_seen)
        begin
            word_seen <= word_s2;
            all_seen <= all_s2;
            run <= 1'b1;
            tcnt <= all_s2 != all_seen ? TCNT_W'(ALL_CYCLES - 1)
                : TCNT_W'(WORD_CYCLES - 1);
        end
        else if (run)
        begin
            if (tcnt == '0)
            begin
                run <= 1'b0;
                done_tgl <= ~done_tgl;
            end
            else
                tcnt <= tcnt - 1'b1;
        end
    end

    // ****************************************
    // storage array, updated when the timer ends
    // ****************************************
    for (genvar i = 0; i < ARRAY_DEPTH; i++)
    begin : g_entry
        always_ff @(posedge sys_clk)
        begin
            if (apply && (all_op || cur_addr == ADDR_W'(i)))
                mem[i] <= prog_value;
        end
    end
endmodule

// *** shared/serial_eeprom_pkg.sv ***
// constants and types of the serial eeprom data memory
package serial_eeprom_pkg;
    // control register location
    localparam logic [7:0] CTRL_ADDR = 8'h40;
    localparam logic [7:0] CTRL_BANK = 8'h01;
    localparam logic [7:0] CTRL_RESET = 8'h80;
    localparam logic [3:0] CTRL_UNUSED = 4'h0;
    localparam int CS_BIT = 4;
    localparam int SK_BIT = 5;
    localparam int DI_BIT = 6;
    localparam int DO_BIT = 7;
    // array geometry
    localparam int ARRAY_DEPTH = 256;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] ADDR_STEP = 8'h01;
    // frame layout after the start bit: opcode then nine bits, the low eight of them the address
    localparam int HEAD_BITS = 11;
    localparam int HEAD_OP_LSB = 9;
    localparam int HEAD_SUB_LSB = 7;
    localparam logic [1:0] OP_READ = 2'b10;
    localparam logic [1:0] OP_ERASE = 2'b11;
    localparam logic [1:0] OP_WRITE = 2'b01;
    localparam logic [1:0] OP_EXT = 2'b00;
    localparam logic [1:0] SUB_ENABLE = 2'b11;
    localparam logic [1:0] SUB_DISABLE = 2'b00;
    localparam logic [1:0] SUB_ERASE_ALL = 2'b10;
    localparam logic [1:0] SUB_WRITE_ALL = 2'b01;
    // self-timed programming on the timer clock
    localparam int TIMER_CLK_PERIOD_NS = 160;
    localparam int WORD_PROG_TIME_MS = 2;
    localparam int ALL_PROG_TIME_MS = 10;
    localparam int NS_PER_MS = 1000000;
    localparam int WORD_PROG_CYCLES = WORD_PROG_TIME_MS * NS_PER_MS / TIMER_CLK_PERIOD_NS;
    localparam int ALL_PROG_CYCLES = ALL_PROG_TIME_MS * NS_PER_MS / TIMER_CLK_PERIOD_NS;

    typedef enum logic [2:0] {st_idle, st_head, st_data, st_read, st_armed, st_busy} frame_state_t;
    typedef enum logic [1:0] {act_write, act_erase, act_erase_all, act_write_all} prog_action_t;
endpackage

// *** testbench/serial_eeprom_monitor.sv ***
// checker of the control register and programming flags
`timescale 1ns/1ps
module serial_eeprom_monitor
#(
    parameter int WORD_CYCLES = 4,
    parameter int ALL_CYCLES = 8
)
(
    input logic sys_clk,
    input logic nrst,
    input logic timer_clk,
    input logic [7:0] bus_addr,
    input logic [7:0] bus_bank,
    input logic indirect_pointer_one_access,
    input logic bus_wr,
    input logic bus_rd,
    input logic [serial_eeprom_pkg::DATA_W-1:0] bus_wdata,
    input logic [serial_eeprom_pkg::DATA_W-1:0] bus_rdata,
    input logic prog_busy,
    input logic prog_enabled
);
    import serial_eeprom_pkg::*;
    localparam int BUSY_MAX = (ALL_CYCLES + 8) * 7;
    logic [2:0] shadow;
    logic [3:0] since_fall;
    logic [7:0] busy_len;
    wire hit = indirect_pointer_one_access && bus_bank == CTRL_BANK && bus_addr == CTRL_ADDR;
    wire cs_drop = hit && bus_wr && shadow[0] && !bus_wdata[CS_BIT];
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            shadow <= 3'h0;
            since_fall <= 4'hF;
            busy_len <= 8'h00;
        end
        else
        begin
            if (hit && bus_wr)
                shadow <= bus_wdata[6:4];
            since_fall <= cs_drop ? 4'h0 : since_fall + {3'h0, since_fall != 4'hF};
            busy_len <= prog_busy ? busy_len + 8'h01 : 8'h00;
        end
    end
    // ****
    // properties
    // ****
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    property p_low_zero; bus_rdata[3:0] == CTRL_UNUSED; endproperty
    a_low_zero: assert property (p_low_zero) else $error("low nibble not zero");
    property p_readback; bus_rd && hit |=> bus_rdata[6:4] == $past(shadow); endproperty
    a_readback: assert property (p_readback) else $error("control bits not read back");
    property p_foreign; !(bus_rd && hit) |=> bus_rdata == 8'h00; endproperty
    a_foreign: assert property (p_foreign) else $error("read data without a hit");
    property p_do_idle;
        bus_rd && hit && !(shadow[0] || $past(shadow[0]) || $past(shadow[0], 2))
        |=> bus_rdata[DO_BIT];
    endproperty
    a_do_idle: assert property (p_do_idle) else $error("data out low while deselected");
    property p_busy_cause; $rose(prog_busy) |-> since_fall <= 4'h3; endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy without select fall");
    property p_busy_enabled; $rose(prog_busy) |-> $past(prog_enabled); endproperty
    a_busy_enabled: assert property (p_busy_enabled) else $error("busy while disabled");
    property p_en_cause; $changed(prog_enabled) |-> since_fall <= 4'h3; endproperty
    a_en_cause: assert property (p_en_cause) else $error("enable moved on its own");
    property p_busy_max; busy_len < BUSY_MAX; endproperty
    a_busy_max: assert property (p_busy_max) else $error("busy too long");
    property p_do_busy;
        bus_rd && hit && shadow[0] && $past(shadow[0]) && $past(shadow[0], 2) && prog_busy
        && $past(prog_busy, 2) |=> !bus_rdata[DO_BIT];
    endproperty
    a_do_busy: assert property (p_do_busy) else $error("data out high while busy");
    c_busy: cover property ($rose(prog_busy));
    c_enable: cover property ($rose(prog_enabled));
    c_do_low: cover property (bus_rd && hit ##1 !bus_rdata[DO_BIT]);
endmodule
bind serial_eeprom_data_memory serial_eeprom_monitor #(.WORD_CYCLES(WORD_CYCLES),
    .ALL_CYCLES(ALL_CYCLES)) i_serial_eeprom_monitor (.sys_clk, .nrst, .timer_clk,
    .bus_addr, .bus_bank, .indirect_pointer_one_access, .bus_wr, .bus_rd, .bus_wdata,
    .bus_rdata, .prog_busy, .prog_enabled);

// *** testbench/serial_cpu_model.sv ***
// cpu side model that bit-bangs the serial control register
`timescale 1ns/1ps
module serial_cpu_model
(
    input wire logic sys_clk,
    input wire logic [serial_eeprom_pkg::DATA_W-1:0] bus_rdata,
    output logic [7:0] bus_addr,
    output logic [7:0] bus_bank,
    output logic indirect_pointer_one_access,
    output logic bus_wr,
    output logic bus_rd,
    output logic [serial_eeprom_pkg::DATA_W-1:0] bus_wdata
);
    import serial_eeprom_pkg::*;
    initial
    begin
        {bus_addr, bus_bank, bus_wdata} = 24'h000000;
        {indirect_pointer_one_access, bus_wr, bus_rd} = 3'b000;
    end
    // ****
    // bus access and serial helpers
    // ****
    task automatic access(input logic [7:0] a, input logic [7:0] b, input logic ind,
        input logic w, input logic [7:0] d, output logic [7:0] q);
        @(negedge sys_clk);
        {bus_addr, bus_bank, indirect_pointer_one_access} = {a, b, ind};
        {bus_wr, bus_rd, bus_wdata} = {w, !w, d};
        @(negedge sys_clk);
        q = bus_rdata;
        // released address, bank and data lines show the inverse, not the last value; write and read go low
        {bus_addr, bus_bank, bus_wr, bus_rd, bus_wdata} = {~a, ~b, 2'b00, ~d};
    endtask
    task automatic ctl(input logic cs, input logic sk, input logic di);
        logic [7:0] q;
        access(CTRL_ADDR, CTRL_BANK, 1'b1, 1'b1, {1'b0, di, sk, cs, 4'h0}, q);
    endtask
    task automatic get(output logic [7:0] q);
        access(CTRL_ADDR, CTRL_BANK, 1'b1, 1'b0, 8'h00, q);
    endtask
    task automatic shift(input logic b);
        ctl(1'b1, 1'b0, b);
        ctl(1'b1, 1'b1, b);
    endtask
    task automatic send(input logic [19:0] f, input int n);
        for (int i = n - 1; i >= 0; i--)
            shift(f[i]);
    endtask
endmodule

// *** testbench/serial_eeprom_data_memory_bench.sv ***
// self-checking bench of the serial eeprom data memory
`timescale 1ns/1ps
module serial_eeprom_data_memory_bench;
    import serial_eeprom_pkg::*;
    logic sys_clk = 1'b0;
    logic timer_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] bus_addr, bus_bank, bus_wdata, bus_rdata;
    logic indirect_pointer_one_access, bus_wr, bus_rd, prog_busy, prog_enabled;
    int n_errors = 0;
    int checked = 0;
    always #12.5 sys_clk = ~sys_clk;
    initial
    begin
        #3.3;
        forever #80 timer_clk = ~timer_clk;
    end
    serial_eeprom_data_memory #(.WORD_CYCLES(4), .ALL_CYCLES(8)) i_serial_eeprom_data_memory (
        .sys_clk, .nrst, .timer_clk, .bus_addr, .bus_bank, .indirect_pointer_one_access,
        .bus_wr, .bus_rd, .bus_wdata, .bus_rdata, .prog_busy, .prog_enabled);
    serial_cpu_model i_serial_cpu_model (.sys_clk, .bus_rdata, .bus_addr, .bus_bank,
        .indirect_pointer_one_access, .bus_wr, .bus_rd, .bus_wdata);
    // ****
    // shared tasks
    // ****
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks=%0d errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic prog(input logic [19:0] f, input int n, input logic busy);
        logic seen;
        logic [7:0] q;
        i_serial_cpu_model.send(f, n);
        i_serial_cpu_model.ctl(1'b0, 1'b0, 1'b0);
        i_serial_cpu_model.ctl(1'b1, 1'b0, 1'b0);
        repeat (2) @(negedge sys_clk);
        seen = prog_busy;
        i_serial_cpu_model.get(q);
        chk8(q, busy ? 8'h10 : 8'h90);
        for (int i = 0; i < 3000 && prog_busy !== 1'b0; i++)
            @(negedge sys_clk);
        if (prog_busy !== 1'b0)
        begin
            n_errors++;
            conclude();
        end
        chk8({7'h00, seen}, {7'h00, busy});
        i_serial_cpu_model.get(q);
        chk8(q, 8'h90);
        i_serial_cpu_model.ctl(1'b0, 1'b0, 1'b0);
    endtask
    task automatic rd_bytes(input logic [7:0] a, input int n, input logic [23:0] e);
        logic [7:0] q;
        logic [7:0] b;
        i_serial_cpu_model.send({8'h00, 1'b1, OP_READ, 1'b0, a}, 12);
        i_serial_cpu_model.get(q);
        chk8(q & 8'h80, 8'h00);
        for (int k = 0; k < n; k++)
        begin
            for (int j = 0; j < 8; j++)
            begin
                i_serial_cpu_model.shift(1'b0);
                i_serial_cpu_model.get(q);
                b = {b[6:0], q[DO_BIT]};
            end
            chk8(b, e[23 - 8 * k -: 8]);
        end
        i_serial_cpu_model.ctl(1'b0, 1'b0, 1'b0);
        repeat (2) @(negedge sys_clk);
        i_serial_cpu_model.get(q);
        chk8(q, CTRL_RESET);
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_reset();
        logic [7:0] q;
        i_serial_cpu_model.get(q);
        chk8(q, CTRL_RESET);
        chk8({7'h00, prog_enabled}, 8'h00);
        i_serial_cpu_model.access(CTRL_ADDR, CTRL_BANK, 1'b0, 1'b1, 8'h10, q);
        i_serial_cpu_model.access(CTRL_ADDR, 8'h00, 1'b1, 1'b1, 8'h10, q);
        i_serial_cpu_model.access(CTRL_ADDR, CTRL_BANK, 1'b0, 1'b0, 8'h00, q);
        chk8(q, 8'h00);
        i_serial_cpu_model.get(q);
        chk8(q, CTRL_RESET);
        $display("reset and decode test done");
    endtask
    task automatic t_erase_all();
        prog({8'h00, 1'b1, OP_EXT, SUB_ERASE_ALL, 7'h00}, 12, 1'b0);
        prog({8'h00, 1'b1, OP_EXT, SUB_ENABLE, 7'h00}, 12, 1'b0);
        chk8({7'h00, prog_enabled}, 8'h01);
        prog({8'h00, 1'b1, OP_EXT, SUB_ERASE_ALL, 7'h00}, 12, 1'b1);
        rd_bytes(8'hFE, 3, 24'hFFFFFF);
        $display("erase all test done");
    endtask
    task automatic t_write();
        prog({1'b1, OP_WRITE, 1'b0, 8'hFF, 8'h55}, 20, 1'b1);
        i_serial_cpu_model.shift(1'b0);
        i_serial_cpu_model.shift(1'b0);
        prog({1'b1, OP_WRITE, 1'b0, 8'h00, 8'hA3}, 20, 1'b1);
        rd_bytes(8'hFF, 2, 24'h55A300);
        prog({8'h00, 1'b1, OP_ERASE, 1'b0, 8'h00}, 12, 1'b1);
        rd_bytes(8'hFF, 2, 24'h55FF00);
        $display("write and erase test done");
    endtask
    task automatic t_write_all();
        prog({1'b1, OP_EXT, SUB_WRITE_ALL, 7'h00, 8'h3C}, 20, 1'b1);
        prog({1'b1, OP_WRITE, 1'b0, 8'h81, 8'hC3}, 20, 1'b1);
        prog({8'h00, 1'b1, OP_EXT, SUB_DISABLE, 7'h00}, 12, 1'b0);
        chk8({7'h00, prog_enabled}, 8'h00);
        prog({1'b1, OP_WRITE, 1'b0, 8'h80, 8'h00}, 20, 1'b0);
        rd_bytes(8'h80, 3, 24'h3CC33C);
        $display("write all and disable test done");
    endtask
    initial
    begin
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk);
        nrst = 1'b1;
        t_reset();
        t_erase_all();
        t_write();
        t_write_all();
        conclude();
    end
endmodule
